//--- hw/powerfail_protection_ctrl.sv
// Powerfail protection controller with timers, interrupts and memory.
//
// Operation
// - Answers only at fixed select code; separate read and write registers.
// - Non-zero write to write register zero cuts battery and line power.
// - With line power present after shutdown, computer restarts normally.
// - Detect power back and one second left; interrupt when enabled.
// - Cause bit 0 failed, bit 1 back, bit 2 one second left.
// - Mask has cause layout; only masked-in events raise the interrupt.
// - After one-second-left, power down when that second expires regardless.
// - Status bit 7 reads one when self test failed.
// - Status bit 2 reads one while battery powers the computer.
// - Status bit 1 reads one only when line power is completely gone.
// - Status bit 0 powerfail state ends when power-back delay reached.
// - Overheat timer accumulates battery time in 10 ms units, read-only.
// - Two seconds back per second down; overheat limits battery time.
// - Power-back timer counts 10 ms units since power restored.
// - Power-back delay, 10 ms units, resets to 50.
// - Powerfail timer counts 10 ms units since latest powerfail.
// - Protection time sets maximum battery backup; resets to 6000.
// - Powerfail delay before power-failed interrupt; resets to 10.
// - Sixty-four byte memory registers at numbers 8 through 71.
// - Memory read returns byte last written to same number.
// - Shut down when powerfail timer reaches the protection time.
// - No power-failed interrupt for losses shorter than powerfail delay.
`timescale 1ns/1ps
module powerfail_protection_ctrl
  import pfail_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] sel_code_i,
  input wire logic [6:0] reg_num_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic mask_wr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic ac_ok_i,
  input wire logic ac_gone_i,
  input wire logic self_test_fail_i,
  output logic [15:0] rd_data_o,
  output logic irq_o,
  output logic power_off_o,
  output logic on_battery_o,
  output logic [7:0] status_o
);
  localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

  pf_state_s s_q;
  pf_state_s s_d;
  host_req_s req;
  logic hit;
  logic tick;
  logic [7:0] status;
  logic [7:0] ev;
  logic [15:0] rdv;
  logic [15:0] used;
  logic [15:0] left;

  function automatic logic [15:0] inc_sat(input logic [15:0] v);
    inc_sat = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  // Register numbers 8 through 71 map onto the retained byte store.
  function automatic logic is_mem_num(input logic [6:0] n);
    is_mem_num = (n >= REG_MEM_FIRST) && (n <= REG_MEM_LAST);
  endfunction

  function automatic logic [5:0] mem_slot(input logic [6:0] n);
    logic [6:0] off;
    off = n - REG_MEM_FIRST;
    mem_slot = off[5:0];
  endfunction

  assign req = '{sel: sel_code_i, num: reg_num_i, rd: rd_i, wr: wr_i,
                 mask_wr: mask_wr_i, data: wr_data_i};
  assign hit = (req.sel == SELECT_CODE);
  assign tick = (s_q.tick_cnt == TICK_LAST);
  // Battery use is charged against whichever of the two budgets is worse.
  assign used = (s_q.overheat > s_q.outage_t) ? s_q.overheat : s_q.outage_t;
  assign left = (used >= s_q.backup_limit) ? 16'h0000
                : s_q.backup_limit - used;

  always_comb begin
    status = 8'h00;
    status[ST_SELF_FAIL] = self_test_fail_i;
    status[ST_ONE_SEC] = s_q.one_sec;
    status[ST_BATTERY] = (s_q.mode == MODE_PFAIL) && !ac_ok_i;
    status[ST_AC_DOWN] = ac_gone_i;
    status[ST_IN_PF] = (s_q.mode == MODE_PFAIL);
  end

  always_comb begin
    rdv = 16'h0000;
    case (req.num)
      REG_ID: rdv = {8'h00, CARD_ID};
      REG_CAUSE: rdv = {8'h00, s_q.cause};
      REG_MASK: rdv = {8'h00, s_q.mask};
      REG_STATUS: rdv = {8'h00, status};
      REG_OVERHEAT: rdv = s_q.overheat;
      REG_RESTORE: rdv = s_q.restore_t;
      REG_OUTAGE: rdv = s_q.outage_t;
      default: begin
        if (is_mem_num(req.num)) begin
          rdv = {8'h00, s_q.mem[mem_slot(req.num)]};
        end
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    ev = 8'h00;
    s_d.tick_cnt = tick ? 18'h00000 : s_q.tick_cnt + 18'h00001;
    case (s_q.mode)
      MODE_NORMAL: begin
        if (!ac_ok_i) begin
          s_d.mode = MODE_PFAIL;
          s_d.outage_t = 16'h0000;
          s_d.restore_t = 16'h0000;
          s_d.failed_sent = 1'b0;
        end else if (tick) begin
          // Cooling runs at half rate: two seconds back per second down.
          s_d.cool_phase = !s_q.cool_phase;
          if (s_q.cool_phase && s_q.overheat != 16'h0000) begin
            s_d.overheat = s_q.overheat - 16'h0001;
          end
        end
      end
      MODE_PFAIL: begin
        if (!ac_ok_i) begin
          s_d.restore_t = 16'h0000;
          if (tick) begin
            s_d.outage_t = inc_sat(s_q.outage_t);
            s_d.overheat = inc_sat(s_q.overheat);
          end
          if (!s_q.failed_sent && s_q.outage_t >= s_q.pf_delay) begin
            ev[CAUSE_FAILED] = 1'b1;
            s_d.failed_sent = 1'b1;
          end
          if (!s_q.one_sec && left <= ONE_SEC_TICKS) begin
            s_d.one_sec = 1'b1;
            s_d.one_sec_cnt = 16'h0000;
            ev[CAUSE_ONE_SEC] = 1'b1;
          end
          if (used >= s_q.backup_limit) begin
            s_d.mode = MODE_OFF;
          end
        end else begin
          if (tick) begin
            s_d.restore_t = inc_sat(s_q.restore_t);
            s_d.outage_t = inc_sat(s_q.outage_t);
          end
          if (s_q.restore_t >= s_q.restore_delay && !s_q.one_sec) begin
            s_d.mode = MODE_NORMAL;
            ev[CAUSE_BACK] = 1'b1;
          end
        end
        if (s_q.one_sec) begin
          if (tick) begin
            s_d.one_sec_cnt = inc_sat(s_q.one_sec_cnt);
          end
          if (s_q.one_sec_cnt >= ONE_SEC_TICKS) begin
            s_d.mode = MODE_OFF;
          end
        end
      end
      MODE_OFF: begin
        // Line power restarts the machine as a fresh powerup.
        if (ac_ok_i) begin
          s_d.mode = MODE_NORMAL;
          s_d.one_sec = 1'b0;
          s_d.outage_t = 16'h0000;
          s_d.restore_t = 16'h0000;
        end
      end
      default: s_d.mode = MODE_NORMAL;
    endcase
    if (hit && req.wr) begin
      case (req.num)
        REG_ID: begin
          if (req.data != 16'h0000) begin
            s_d.mode = MODE_OFF;
          end
        end
        REG_RESTORE: s_d.restore_delay = req.data;
        REG_OUTAGE: s_d.backup_limit = req.data;
        REG_PF_DELAY: s_d.pf_delay = req.data;
        default: begin
          if (is_mem_num(req.num)) begin
            s_d.mem[mem_slot(req.num)] = req.data[7:0];
          end
        end
      endcase
    end
    if (hit && req.mask_wr) begin
      s_d.mask = req.data[7:0] & 8'h07;
    end
    if (hit && req.rd) begin
      s_d.rd_data = rdv;
    end
    // A new event in the read cycle survives the clear.
    if (hit && req.rd && req.num == REG_CAUSE) begin
      s_d.cause = ev & 8'h07;
    end else begin
      s_d.cause = s_q.cause | (ev & 8'h07);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
      s_q.mode <= MODE_NORMAL;
      s_q.restore_delay <= RESTORE_DELAY_RST;
      s_q.backup_limit <= BACKUP_LIMIT_RST;
      s_q.pf_delay <= PF_DELAY_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data_o = s_q.rd_data;
  assign irq_o = |(s_q.cause & s_q.mask);
  assign power_off_o = (s_q.mode == MODE_OFF);
  assign on_battery_o = status[ST_BATTERY];
  assign status_o = status;
endmodule

//--- pkg/pfail_pkg.sv
// Constants and types shared by the powerfail protection controller.
package pfail_pkg;
  localparam logic [4:0] SELECT_CODE = 5'h05;
  // Card identification value is arbitrary.
  localparam logic [7:0] CARD_ID = 8'h2A;
  localparam logic [6:0] REG_ID = 7'h00;
  localparam logic [6:0] REG_CAUSE = 7'h01;
  localparam logic [6:0] REG_MASK = 7'h02;
  localparam logic [6:0] REG_STATUS = 7'h03;
  localparam logic [6:0] REG_OVERHEAT = 7'h04;
  localparam logic [6:0] REG_RESTORE = 7'h05;
  localparam logic [6:0] REG_OUTAGE = 7'h06;
  localparam logic [6:0] REG_PF_DELAY = 7'h07;
  localparam logic [6:0] REG_MEM_FIRST = 7'h08;
  localparam logic [6:0] REG_MEM_LAST = 7'h47;
  localparam int CAUSE_FAILED = 0;
  localparam int CAUSE_BACK = 1;
  localparam int CAUSE_ONE_SEC = 2;
  localparam int ST_IN_PF = 0;
  localparam int ST_AC_DOWN = 1;
  localparam int ST_BATTERY = 2;
  localparam int ST_ONE_SEC = 3;
  localparam int ST_SELF_FAIL = 7;
  localparam logic [15:0] RESTORE_DELAY_RST = 16'h0032;
  localparam logic [15:0] BACKUP_LIMIT_RST = 16'h1770;
  localparam logic [15:0] PF_DELAY_RST = 16'h000A;
  localparam logic [15:0] ONE_SEC_TICKS = 16'h0064;
  localparam int TICK_TIME_MS = 10;
  localparam int CLK_FREQ_KHZ = 20000;
  localparam int TICK_CYCLES_DEF = TICK_TIME_MS * CLK_FREQ_KHZ;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_PFAIL = 3'b010,
    MODE_OFF = 3'b100
  } mode_e;

  typedef struct packed {
    logic [4:0] sel;
    logic [6:0] num;
    logic rd;
    logic wr;
    logic mask_wr;
    logic [15:0] data;
  } host_req_s;

  typedef struct packed {
    mode_e mode;
    logic [17:0] tick_cnt;
    logic cool_phase;
    logic failed_sent;
    logic one_sec;
    logic [15:0] one_sec_cnt;
    logic [15:0] overheat;
    logic [15:0] restore_t;
    logic [15:0] outage_t;
    logic [15:0] restore_delay;
    logic [15:0] backup_limit;
    logic [15:0] pf_delay;
    logic [7:0] cause;
    logic [7:0] mask;
    logic [15:0] rd_data;
    logic [63:0][7:0] mem;
  } pf_state_s;
endpackage

//--- sim/ac_supply_model.sv
// Line supply and backup battery as seen from the controller's pins.
`timescale 1ns/1ps
module ac_supply_model (
  input wire logic clk_i,
  input wire logic fail_i,
  input wire logic brown_i,
  output logic ac_ok_o,
  output logic ac_gone_o
);
  // A brown-out sags the line without losing it, so only the ok flag drops.
  initial begin
    ac_ok_o = 1'b1;
    ac_gone_o = 1'b0;
    forever begin
      @(negedge clk_i);
      ac_ok_o <= !(fail_i || brown_i);
      ac_gone_o <= fail_i;
    end
  end
endmodule

//--- sim/pf_props.sv
// Port checker for the powerfail protection controller.
`timescale 1ns/1ps
module pf_props
  import pfail_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] sel_code_i,
  input wire logic [6:0] reg_num_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic ac_ok_i,
  input wire logic ac_gone_i,
  input wire logic self_test_fail_i,
  input wire logic [15:0] rd_data_o,
  input wire logic power_off_o,
  input wire logic on_battery_o,
  input wire logic [7:0] status_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic hit;
  assign hit = sel_code_i == SELECT_CODE;
  a_id_read: assert property (rd_i && hit && reg_num_i == REG_ID
    |=> rd_data_o == {8'h00, CARD_ID}) else $error("bad card id");
  a_foreign_read: assert property (rd_i && !hit
    |=> $stable(rd_data_o)) else $error("foreign read answered");
  a_unused_read: assert property (rd_i && hit &&
    (reg_num_i > REG_MEM_LAST || reg_num_i == REG_PF_DELAY)
    |=> rd_data_o == 16'h0000) else $error("unused read not zero");
  a_shut_cmd: assert property (wr_i && hit && reg_num_i == REG_ID &&
    wr_data_i != 16'h0000 && !ac_ok_i |=> power_off_o)
    else $error("shutdown ignored");
  a_line_restart: assert property (power_off_o && ac_ok_i
    |-> ##[1:3] !power_off_o) else $error("no restart");
  a_self_test: assert property (
    status_o[ST_SELF_FAIL] == self_test_fail_i)
    else $error("self test bit wrong");
  a_ac_down: assert property (status_o[ST_AC_DOWN] == ac_gone_i)
    else $error("ac down bit wrong");
  a_battery_use: assert property (
    status_o[ST_BATTERY] == on_battery_o &&
    on_battery_o == (status_o[ST_IN_PF] && !ac_ok_i))
    else $error("battery bit wrong");
endmodule
bind powerfail_protection_ctrl pf_props pf_props_i (.clk_i(clk_i),
  .reset_n_i(reset_n_i), .sel_code_i(sel_code_i), .reg_num_i(reg_num_i),
  .rd_i(rd_i), .wr_i(wr_i), .wr_data_i(wr_data_i), .ac_ok_i(ac_ok_i),
  .ac_gone_i(ac_gone_i), .self_test_fail_i(self_test_fail_i),
  .rd_data_o(rd_data_o), .power_off_o(power_off_o),
  .on_battery_o(on_battery_o), .status_o(status_o));

//--- sim/powerfail_protection_ctrl_tb.sv
// Self-checking bench for the powerfail protection controller.
`timescale 1ns/1ps
module powerfail_protection_ctrl_tb
  import pfail_pkg::*;
;
  logic clk_i = 1'b0, reset_n_i = 1'b0, rd = 1'b0, wr = 1'b0, mw = 1'b0;
  logic stf = 1'b0, fail = 1'b0, brown = 1'b0, off_seen;
  logic [4:0] sel = 5'h05;
  logic [6:0] num = 7'h00;
  logic [15:0] dat = 16'h0000, rdat;
  logic ac_ok, ac_gone, irq, off, batt;
  logic [7:0] stat;
  int err_total = 0, samples_checked = 0;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  err_total++; $display("Error %s expected %h seen %h", n, e, g); end end
  initial forever #25 clk_i = ~clk_i;
  powerfail_protection_ctrl #(.TICK_CYCLES(20)) powerfail_protection_ctrl_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .sel_code_i(sel), .reg_num_i(num),
    .rd_i(rd), .wr_i(wr), .mask_wr_i(mw), .wr_data_i(dat), .ac_ok_i(ac_ok),
    .ac_gone_i(ac_gone), .self_test_fail_i(stf), .rd_data_o(rdat),
    .irq_o(irq), .power_off_o(off), .on_battery_o(batt), .status_o(stat));
  ac_supply_model ac_supply_model_i (.clk_i(clk_i), .fail_i(fail),
    .brown_i(brown), .ac_ok_o(ac_ok), .ac_gone_o(ac_gone));
  // A shutdown with the line present may last one cycle, so keep a flag.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) off_seen <= 1'b0;
    else if (off) off_seen <= 1'b1;
  end
  task acc(input logic [4:0] s, input logic [6:0] n, input logic r, w, m,
           input logic [15:0] d);
    @(negedge clk_i);
    {sel, num, rd, wr, mw, dat} = {s, n, r, w, m, d};
    @(negedge clk_i);
    {rd, wr, mw} = 3'h0;
  endtask
  task rdc(input string nm, input logic [6:0] n, input logic [15:0] e);
    acc(5'h05, n, 1'b1, 1'b0, 1'b0, 16'h0000);
    `CHK(nm, e, rdat)
  endtask
  task wrg(input logic [6:0] n, input logic [15:0] d);
    acc(5'h05, n, 1'b0, 1'b1, 1'b0, d);
  endtask
  task rst();
    reset_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    reset_n_i = 1'b1;
  endtask
  task t_regs();
    rst();
    rdc("id", REG_ID, {8'h00, CARD_ID});
    wrg(7'h48, 16'h00A5);
    rdc("unused", 7'h48, 16'h0000);
    rdc("st7", REG_PF_DELAY, 16'h0000);
    wrg(REG_MEM_FIRST, 16'h005A);
    wrg(REG_MEM_LAST, 16'h00C3);
    rdc("mem8", REG_MEM_FIRST, 16'h005A);
    rdc("mem71", REG_MEM_LAST, 16'h00C3);
    acc(5'h04, REG_MEM_FIRST, 1'b1, 1'b1, 1'b0, 16'h0011);
    `CHK("foreign", 16'h00C3, rdat)
    rdc("kept", REG_MEM_FIRST, 16'h005A);
    stf = 1'b1;
    rdc("selftest", REG_STATUS, 16'h0080);
    stf = 1'b0;
    $display("t_regs done");
  endtask
  task t_outage();
    rst();
    acc(5'h05, REG_ID, 1'b0, 1'b0, 1'b1, 16'h0002);
    fail = 1'b1;
    repeat (300) @(negedge clk_i);
    rdc("pf", REG_STATUS, 16'h0007);
    `CHK("masked", 1'b0, irq)
    acc(5'h05, REG_OUTAGE, 1'b1, 1'b0, 1'b0, 16'h0000);
    `CHK("outage", 1'b1, rdat > 16'd12 && rdat < 16'd17)
    acc(5'h05, REG_OVERHEAT, 1'b1, 1'b0, 1'b0, 16'h0000);
    `CHK("overheat", 1'b1, rdat > 16'd12 && rdat < 16'd17)
    rdc("cause1", REG_CAUSE, 16'h0001);
    fail = 1'b0;
    repeat (900) @(negedge clk_i);
    acc(5'h05, REG_RESTORE, 1'b1, 1'b0, 1'b0, 16'h0000);
    `CHK("restore", 1'b1, rdat > 16'd39 && rdat < 16'd48)
    `CHK("still pf", 1'b1, stat[ST_IN_PF])
    repeat (200) @(negedge clk_i);
    `CHK("left pf", 1'b0, stat[ST_IN_PF])
    `CHK("back irq", 1'b1, irq)
    rdc("cause2", REG_CAUSE, 16'h0002);
    `CHK("irq clr", 1'b0, irq)
    acc(5'h05, REG_OVERHEAT, 1'b1, 1'b0, 1'b0, 16'h0000);
    `CHK("cooling", 1'b1, rdat > 16'd11 && rdat < 16'd15)
    fail = 1'b1;
    repeat (100) @(negedge clk_i);
    fail = 1'b0;
    repeat (1100) @(negedge clk_i);
    rdc("short", REG_CAUSE, 16'h0002);
    $display("t_outage done");
  endtask
  task t_shut();
    rst();
    brown = 1'b1;
    repeat (5) @(negedge clk_i);
    rdc("brown", REG_STATUS, 16'h0005);
    `CHK("batt", 1'b1, batt)
    acc(5'h04, REG_ID, 1'b0, 1'b1, 1'b0, 16'h0001);
    `CHK("foreign off", 1'b0, off)
    wrg(REG_ID, 16'h0000);
    `CHK("zero off", 1'b0, off)
    wrg(REG_ID, 16'h0080);
    repeat (50) @(negedge clk_i);
    `CHK("off", 1'b1, off)
    brown = 1'b0;
    repeat (4) @(negedge clk_i);
    `CHK("restart", 1'b0, off)
    // A tiny limit ends backup long before the one-second path could.
    wrg(REG_OUTAGE, 16'h0014);
    brown = 1'b1;
    repeat (500) @(negedge clk_i);
    `CHK("limit off", 1'b1, off)
    brown = 1'b0;
    $display("t_shut done");
  endtask
  task t_onesec();
    rst();
    acc(5'h05, REG_ID, 1'b0, 1'b0, 1'b1, 16'h0004);
    wrg(REG_OUTAGE, 16'h00C8);
    fail = 1'b1;
    repeat (2400) @(negedge clk_i);
    rdc("onesec", REG_STATUS, 16'h000F);
    `CHK("one irq", 1'b1, irq)
    rdc("cause4", REG_CAUSE, 16'h0005);
    fail = 1'b0;
    `CHK("early off", 1'b0, off_seen)
    repeat (2000) @(negedge clk_i);
    `CHK("late off", 1'b1, off_seen)
    $display("t_onesec done");
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    t_regs();
    t_outage();
    t_shut();
    t_onesec();
    test_done();
  end
  // The tests take about 7600 cycles; the 20000-cycle limit means a hang.
  initial begin
    #1000000;
    err_total++;
    test_done();
  end
endmodule
